//--- src/prt_pkg.sv
// constants for the recovery counter and sequencer trigger register bank
package prt_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] RECOV_STATUS_OFS = 8'h83;
  localparam logic [7:0] RECOV_CONTROL_OFS = 8'h84;
  localparam logic [7:0] SEQ_TRIGGERS_OFS = 8'h85;
  localparam logic [7:0] SLEEP_MIRROR_OFS = 8'h86;
  localparam logic [7:0] CONV_RESET_OFS = 8'h87;
  localparam logic [7:0] SPREAD_CTRL_OFS = 8'h88;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RECOV_COUNT_LSB = 0;
  localparam int RECOV_COUNT_W = 4;
  localparam int RECOV_THRESH_LSB = 0;
  localparam int RECOV_THRESH_W = 4;
  localparam int RECOV_CLEAR_BIT = 4;
  localparam int TRIG_PULSE_LSB = 0;
  localparam int TRIG_PULSE_W = 4;
  localparam int TRIG_LEVEL_LSB = 4;
  localparam int TRIG_LEVEL_W = 4;
  localparam int SLEEP1_MIRROR_BIT = 0;
  localparam int SLEEP2_MIRROR_BIT = 1;
  localparam int CONV_RESET_LSB = 0;
  localparam int CONV_RESET_W = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0] RECOV_COUNT_RST = 4'h0;
  localparam logic [3:0] RECOV_THRESH_RST = 4'h0;
  localparam logic [3:0] TRIG_RST = 4'h0;
  localparam logic [1:0] SLEEP_MIRROR_RST = 2'h0;
  localparam logic [3:0] CONV_RESET_RST = 4'h0;
  localparam logic [7:0] SPREAD_CTRL_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------
  // recovery counter limit
  // ----------------------------------------
  localparam logic [3:0] RECOV_COUNT_MAX = 4'hF;

endpackage : prt_pkg

//--- src/prt_regs.sv
// register bank: recovery counter, sequencer triggers, sleep mirrors, converter resets
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [R01] a four-bit recovery count counts up once per warm reset and holds at 15
// [R02] recovery count is read-only; upper four status bits read zero
// [R03] writing one to control bit 4 clears the recovery count
// [R04] the recovery clear bit returns to zero by itself
// [R05] four-bit threshold is read-write, default loaded from nonvolatile memory
// [R06] count at or above nonzero threshold forces all rails down; zero disables
// [R07] writing one to trigger bits 3..0 pulses the sequencer, then bits self-clear
// [R08] trigger bits 7..4 are plain read-write levels into the sequencer, reset zero
// [R09] each self-clearing trigger pulse lasts exactly one clock cycle
// [R10] sleep mirror bit 1 copies the second sleep request, one means high
// [R11] sleep mirror bit 0 copies the first sleep request; bits 7..2 reserved
// [R12] converter reset bits 3..0 drive converter logic resets, default from memory
module prt_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // nonvolatile defaults
  input wire logic nvmLoad,
  input wire logic [3:0] nvmThreshold,
  input wire logic [3:0] nvmConvReset,
  // device events
  input wire logic warmResetEvent,
  // sequencer and power outputs
  output logic [3:0] seqTrigPulse,
  output logic [3:0] seqTrigLevel,
  output logic firstSleepMirror,
  output logic secondSleepMirror,
  output logic [3:0] convLogicReset,
  output logic powerDownAll,
  output logic [7:0] spreadCtrl
);

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic wrControl;
  logic wrTrig;
  logic wrSleep;
  logic wrConv;
  logic wrSpread;

  always_comb begin
    wrControl = 1'b0;
    wrTrig = 1'b0;
    wrSleep = 1'b0;
    wrConv = 1'b0;
    wrSpread = 1'b0;
    if (!regWrEn) begin
      wrControl = 1'b0;
    end else if (regAddr == prt_pkg::RECOV_STATUS_OFS) begin
      // the count is read-only, so a write to it is dropped here [R02]
      wrControl = 1'b0;
    end else if (regAddr == prt_pkg::RECOV_CONTROL_OFS) begin
      wrControl = 1'b1;
    end else if (regAddr == prt_pkg::SEQ_TRIGGERS_OFS) begin
      wrTrig = 1'b1;
    end else if (regAddr == prt_pkg::SLEEP_MIRROR_OFS) begin
      wrSleep = 1'b1;
    end else if (regAddr == prt_pkg::CONV_RESET_OFS) begin
      wrConv = 1'b1;
    end else if (regAddr == prt_pkg::SPREAD_CTRL_OFS) begin
      wrSpread = 1'b1;
    end
  end

  // ----------------------------------------
  // write data fields
  // ----------------------------------------
  logic clearWrite;
  logic [3:0] threshWrite;
  logic [3:0] pulseWrite;
  logic [3:0] levelWrite;
  logic [1:0] sleepWrite;
  logic [3:0] convWrite;

  assign clearWrite = regWrData[prt_pkg::RECOV_CLEAR_BIT];
  assign threshWrite = regWrData[prt_pkg::RECOV_THRESH_LSB +: prt_pkg::RECOV_THRESH_W];
  assign pulseWrite = regWrData[prt_pkg::TRIG_PULSE_LSB +: prt_pkg::TRIG_PULSE_W];
  assign levelWrite = regWrData[prt_pkg::TRIG_LEVEL_LSB +: prt_pkg::TRIG_LEVEL_W];
  assign sleepWrite[0] = regWrData[prt_pkg::SLEEP1_MIRROR_BIT];
  assign sleepWrite[1] = regWrData[prt_pkg::SLEEP2_MIRROR_BIT];
  assign convWrite = regWrData[prt_pkg::CONV_RESET_LSB +: prt_pkg::CONV_RESET_W];

  // ----------------------------------------
  // recovery counter and threshold
  // ----------------------------------------
  logic [3:0] recovCount_r;
  logic [3:0] recovCount_nxt;
  logic recovClear_r;
  logic recovClear_nxt;
  logic [3:0] recovThresh_r;
  logic [3:0] recovThresh_nxt;
  logic powerDown_r;
  logic powerDown_nxt;
  logic countAtMax;
  logic thresholdArmed;
  logic thresholdMet;

  // a zero threshold switches the forced power-down off altogether
  assign countAtMax = (recovCount_r == prt_pkg::RECOV_COUNT_MAX);
  assign thresholdArmed = (recovThresh_r != 4'h0); // [R06]
  assign thresholdMet = (recovCount_r >= recovThresh_r); // [R06]

  always_comb begin
    recovCount_nxt = recovCount_r;
    // the pending clear acts one cycle after the write, then drops [R03]
    if (recovClear_r) begin
      recovCount_nxt = prt_pkg::RECOV_COUNT_RST; // [R03]
    end
    // a warm reset in the clear cycle still counts: set wins over clear;
    // saturate rather than wrap so a long fault history never looks clean
    if (warmResetEvent) begin
      if (recovClear_r) begin
        recovCount_nxt = 4'h1; // [R01]
      end else if (!countAtMax) begin
        recovCount_nxt = recovCount_r + 4'h1; // [R01]
      end
    end
    recovClear_nxt = 1'b0; // [R04]
    if (wrControl) begin
      recovClear_nxt = clearWrite; // [R03]
    end
    recovThresh_nxt = recovThresh_r;
    if (wrControl) begin
      recovThresh_nxt = threshWrite; // [R05]
    end else if (nvmLoad) begin
      recovThresh_nxt = nvmThreshold; // [R05]
    end
    powerDown_nxt = thresholdArmed && thresholdMet; // [R06]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      recovCount_r <= prt_pkg::RECOV_COUNT_RST;
      recovClear_r <= 1'b0;
      recovThresh_r <= prt_pkg::RECOV_THRESH_RST;
      powerDown_r <= 1'b0;
    end else begin
      recovCount_r <= recovCount_nxt;
      recovClear_r <= recovClear_nxt;
      recovThresh_r <= recovThresh_nxt;
      powerDown_r <= powerDown_nxt;
    end
  end

  assign powerDownAll = powerDown_r; // [R06]

  // ----------------------------------------
  // sequencer triggers
  // ----------------------------------------
  logic [3:0] trigPulse_r;
  logic [3:0] trigPulse_nxt;
  logic [3:0] trigLevel_r;
  logic [3:0] trigLevel_nxt;

  always_comb begin
    trigPulse_nxt = prt_pkg::TRIG_RST; // [R07] [R09]
    trigLevel_nxt = trigLevel_r;
    if (wrTrig) begin
      trigPulse_nxt = pulseWrite; // [R07]
      trigLevel_nxt = levelWrite; // [R08]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trigPulse_r <= prt_pkg::TRIG_RST;
      trigLevel_r <= prt_pkg::TRIG_RST; // [R08]
    end else begin
      trigPulse_r <= trigPulse_nxt;
      trigLevel_r <= trigLevel_nxt;
    end
  end

  // pulse bits are the stored bits themselves, so they read back as one
  // only during the single pulse cycle
  assign seqTrigPulse = trigPulse_r; // [R09]
  assign seqTrigLevel = trigLevel_r; // [R08]

  // ----------------------------------------
  // sleep mirrors, converter resets, spread spectrum
  // ----------------------------------------
  logic [1:0] sleepMirror_r;
  logic [1:0] sleepMirror_nxt;
  logic [3:0] convReset_r;
  logic [3:0] convReset_nxt;
  logic [7:0] spread_r;
  logic [7:0] spread_nxt;

  always_comb begin
    sleepMirror_nxt = sleepMirror_r;
    convReset_nxt = convReset_r;
    spread_nxt = spread_r;
    if (wrSleep) begin
      sleepMirror_nxt[0] = sleepWrite[0]; // [R11]
      sleepMirror_nxt[1] = sleepWrite[1]; // [R10]
    end
    if (wrConv) begin
      convReset_nxt = convWrite; // [R12]
    end else if (nvmLoad) begin
      convReset_nxt = nvmConvReset; // [R12]
    end
    if (wrSpread) begin
      spread_nxt = regWrData;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleepMirror_r <= prt_pkg::SLEEP_MIRROR_RST;
      convReset_r <= prt_pkg::CONV_RESET_RST;
      spread_r <= prt_pkg::SPREAD_CTRL_RST;
    end else begin
      sleepMirror_r <= sleepMirror_nxt;
      convReset_r <= convReset_nxt;
      spread_r <= spread_nxt;
    end
  end

  assign firstSleepMirror = sleepMirror_r[0]; // [R11]
  assign secondSleepMirror = sleepMirror_r[1]; // [R10]
  assign convLogicReset = convReset_r; // [R12]
  assign spreadCtrl = spread_r;

  // ----------------------------------------
  // readback words
  // ----------------------------------------
  // reserved bits are not stored, so every word starts from zero
  logic [7:0] statusWord;
  logic [7:0] controlWord;
  logic [7:0] trigWord;
  logic [7:0] sleepWord;
  logic [7:0] convWord;

  always_comb begin
    statusWord = prt_pkg::READ_ZERO;
    statusWord[prt_pkg::RECOV_COUNT_LSB +: prt_pkg::RECOV_COUNT_W] = recovCount_r; // [R02]
    controlWord = prt_pkg::READ_ZERO;
    controlWord[prt_pkg::RECOV_THRESH_LSB +: prt_pkg::RECOV_THRESH_W] = recovThresh_r; // [R05]
    // the clear bit reads one only in the cycle in which the clear is applied
    controlWord[prt_pkg::RECOV_CLEAR_BIT] = recovClear_r; // [R04]
    trigWord = prt_pkg::READ_ZERO;
    trigWord[prt_pkg::TRIG_PULSE_LSB +: prt_pkg::TRIG_PULSE_W] = trigPulse_r; // [R07]
    trigWord[prt_pkg::TRIG_LEVEL_LSB +: prt_pkg::TRIG_LEVEL_W] = trigLevel_r; // [R08]
    sleepWord = prt_pkg::READ_ZERO;
    sleepWord[prt_pkg::SLEEP1_MIRROR_BIT] = sleepMirror_r[0]; // [R11]
    sleepWord[prt_pkg::SLEEP2_MIRROR_BIT] = sleepMirror_r[1]; // [R10]
    convWord = prt_pkg::READ_ZERO;
    convWord[prt_pkg::CONV_RESET_LSB +: prt_pkg::CONV_RESET_W] = convReset_r; // [R12]
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rdMux;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;

  always_comb begin
    rdMux = prt_pkg::READ_ZERO;
    if (regAddr == prt_pkg::RECOV_STATUS_OFS) begin
      rdMux = statusWord; // [R02]
    end else if (regAddr == prt_pkg::RECOV_CONTROL_OFS) begin
      rdMux = controlWord; // [R04] [R05]
    end else if (regAddr == prt_pkg::SEQ_TRIGGERS_OFS) begin
      rdMux = trigWord;
    end else if (regAddr == prt_pkg::SLEEP_MIRROR_OFS) begin
      rdMux = sleepWord; // [R11]
    end else if (regAddr == prt_pkg::CONV_RESET_OFS) begin
      rdMux = convWord;
    end else if (regAddr == prt_pkg::SPREAD_CTRL_OFS) begin
      rdMux = spread_r;
    end
    rdData_nxt = rdData_r;
    if (regRdEn) begin
      rdData_nxt = rdMux;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= prt_pkg::READ_ZERO;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

endmodule : prt_regs

`default_nettype wire

//--- verif/prt_regs_sva.sv
// checker for the recovery counter and trigger register bank
`timescale 1ns/100ps
`default_nettype none
module prt_regs_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // defaults and outputs
  input wire logic nvmLoad,
  input wire logic [3:0] nvmConvReset,
  input wire logic [3:0] seqTrigPulse,
  input wire logic [3:0] seqTrigLevel,
  input wire logic firstSleepMirror,
  input wire logic secondSleepMirror,
  input wire logic [3:0] convLogicReset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wT, wS, wC, wR;
  assign wT = regWrEn && regAddr == prt_pkg::SEQ_TRIGGERS_OFS;
  assign wS = regWrEn && regAddr == prt_pkg::SLEEP_MIRROR_OFS;
  assign wC = regWrEn && regAddr == prt_pkg::CONV_RESET_OFS;
  assign wR = regAddr == prt_pkg::RECOV_CONTROL_OFS;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_pulse; wT |=> seqTrigPulse == $past(regWrData[3:0]); endproperty
  a_pulse: assert property (p_pulse) else $error("trigger pulse wrong");
  property p_pulse_len; !wT |=> seqTrigPulse == 4'h0; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse too long");
  property p_level; wT |=> seqTrigLevel == $past(regWrData[7:4]); endproperty
  a_level: assert property (p_level) else $error("trigger level wrong");
  property p_level_hold; !wT |=> $stable(seqTrigLevel); endproperty
  a_level_hold: assert property (p_level_hold) else $error("level moved");
  property p_sleep;
    wS |=> {secondSleepMirror, firstSleepMirror} == $past(regWrData[1:0]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep mirror wrong");
  property p_conv; wC |=> convLogicReset == $past(regWrData[3:0]); endproperty
  a_conv: assert property (p_conv) else $error("converter reset wrong");
  property p_nvm; nvmLoad && !wC |=> convLogicReset == $past(nvmConvReset); endproperty
  a_nvm: assert property (p_nvm) else $error("converter default wrong");
  property p_status;
    regRdEn && regAddr == prt_pkg::RECOV_STATUS_OFS |=> regRdData[7:4] == 4'h0;
  endproperty
  a_status: assert property (p_status) else $error("status upper bits set");
  property p_thresh;
    (regWrEn && wR) ##1 (!regWrEn && !nvmLoad) ##1 (regRdEn && wR && !regWrEn && !nvmLoad)
      |=> regRdData[3:0] == $past(regWrData[3:0], 3);
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold readback wrong");
endmodule : prt_regs_sva
bind prt_regs prt_regs_sva u_sva (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .nvmLoad(nvmLoad), .nvmConvReset(nvmConvReset), .seqTrigPulse(seqTrigPulse),
  .seqTrigLevel(seqTrigLevel), .firstSleepMirror(firstSleepMirror),
  .secondSleepMirror(secondSleepMirror), .convLogicReset(convLogicReset));
`default_nettype wire

//--- verif/prt_regs_tb.sv
// testbench for the recovery counter and trigger register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module prt_regs_tb;
  logic clock, rst_n, regWrEn, regRdEn, nvmLoad, warmResetEvent;
  logic [7:0] regAddr, regWrData, regRdData, spreadCtrl, rdv;
  logic [3:0] nvmThreshold, nvmConvReset, seqTrigPulse, seqTrigLevel, convLogicReset;
  logic firstSleepMirror, secondSleepMirror, powerDownAll;
  int n_errors = 0;
  int checks_done = 0;
  prt_regs DUT (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .nvmLoad(nvmLoad),
    .nvmThreshold(nvmThreshold), .nvmConvReset(nvmConvReset),
    .warmResetEvent(warmResetEvent), .seqTrigPulse(seqTrigPulse),
    .seqTrigLevel(seqTrigLevel), .firstSleepMirror(firstSleepMirror),
    .secondSleepMirror(secondSleepMirror), .convLogicReset(convLogicReset),
    .powerDownAll(powerDownAll), .spreadCtrl(spreadCtrl));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // host port cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clock);
    regRdEn = 1'b0;
    rdv = regRdData;
  endtask : rd
  task automatic warm;
    @(negedge clock);
    warmResetEvent = 1'b1;
    @(negedge clock);
    warmResetEvent = 1'b0;
  endtask : warm
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    // 0x80 is unmapped and must read zero too
    for (int i = 0; i < 7; i++) begin
      rd((i == 6) ? 8'h80 : 8'h83 + 8'(i));
      `CHK(rdv, 8'h00)
    end
  endtask : t_reset
  task automatic t_count;
    repeat (3) warm();
    rd(8'h83);
    `CHK(rdv, 8'h03)
    wr(8'h83, 8'hFF);
    rd(8'h83);
    `CHK(rdv, 8'h03)
    wr(8'h84, 8'h04);
    @(negedge clock);
    `CHK(powerDownAll, 1'b0)
    warm();
    @(negedge clock);
    `CHK(powerDownAll, 1'b1)
    wr(8'h84, 8'h00);
    @(negedge clock);
    `CHK(powerDownAll, 1'b0)
    wr(8'h84, 8'h10);
    repeat (2) @(negedge clock);
    rd(8'h84);
    `CHK(rdv, 8'h00)
    rd(8'h83);
    `CHK(rdv, 8'h00)
  endtask : t_count
  task automatic t_trig;
    logic [7:0] v[2] = '{8'hA5, 8'h5A};
    foreach (v[i]) begin
      wr(8'h85, v[i]);
      `CHK(seqTrigPulse, v[i][3:0])
      `CHK(seqTrigLevel, v[i][7:4])
      @(negedge clock);
      `CHK(seqTrigPulse, 4'h0)
      rd(8'h85);
      `CHK(rdv, {v[i][7:4], 4'h0})
    end
  endtask : t_trig
  task automatic t_sleep;
    wr(8'h86, 8'hFF);
    rd(8'h86);
    `CHK(rdv, 8'h03)
    wr(8'h86, 8'h02);
    `CHK(secondSleepMirror, 1'b1)
    `CHK(firstSleepMirror, 1'b0)
  endtask : t_sleep
  task automatic t_nvm;
    @(negedge clock);
    nvmThreshold = 4'h3;
    nvmConvReset = 4'h9;
    nvmLoad = 1'b1;
    @(negedge clock);
    nvmLoad = 1'b0;
    `CHK(convLogicReset, 4'h9)
    rd(8'h84);
    `CHK(rdv, 8'h03)
    wr(8'h84, 8'h07);
    rd(8'h84);
    `CHK(rdv, 8'h07)
    wr(8'h87, 8'hF6);
    `CHK(convLogicReset, 4'h6)
    rd(8'h87);
    `CHK(rdv, 8'h06)
    wr(8'h88, 8'hC3);
    `CHK(spreadCtrl, 8'hC3)
    rd(8'h88);
    `CHK(rdv, 8'hC3)
  endtask : t_nvm
  initial begin
    {rst_n, regWrEn, regRdEn, nvmLoad, warmResetEvent} = 5'h00;
    {regAddr, regWrData, nvmThreshold, nvmConvReset} = 24'h000000;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_count();
    t_trig();
    t_sleep();
    t_nvm();
    close_out();
  end
  // the run needs under a hundred cycles; this 2000-cycle limit is over twenty times that
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
endmodule : prt_regs_tb
`default_nettype wire
